// File: common/pfcc_consts.vh
`ifndef PFCC_CONSTS_VH
`define PFCC_CONSTS_VH
// Register byte offsets
`define PFCC_OFS_MODSEL   12'h000
`define PFCC_OFS_FNCSEL   12'h004
`define PFCC_OFS_CLKCTL   12'h008
`define PFCC_OFS_INTGRP   12'h00C
`define PFCC_OFS_INTFLAG  12'h010
`define PFCC_OFS_INTEN    12'h014
`define PFCC_OFS_UNLOCK   12'h018
// Clock control fields
`define PFCC_DBG_RUN_BIT  8
`define PFCC_DIV_MSB      7
`define PFCC_DIV_LSB      4
`define PFCC_KRST_MSB     3
`define PFCC_KRST_LSB     2
`define PFCC_SRC_MSB      1
`define PFCC_SRC_LSB      0
`define PFCC_CLKCTL_MASK  16'h01FF
// Sources
`define PFCC_SRC_INT      2'h0
`define PFCC_SRC_LOSC     2'h1
`define PFCC_SRC_HOSC     2'h2
`define PFCC_SRC_EXT      2'h3
// Key reset codes
`define PFCC_KRST_OFF     2'h0
`define PFCC_KRST_2       2'h1
`define PFCC_KRST_3       2'h2
`define PFCC_KRST_4       2'h3
// Unlock key value
`define PFCC_UNLOCK_KEY   16'h0096
`define PFCC_RST16        16'h0000
`endif

// File: hw/pfcc_top.v
// Purpose: shared port control: function select, filter clock, key reset, group interrupt summary.
// Assumes: inputs synchronous to clk; source clocks arrive as one-cycle enable pulses.
// Notes: APB slave, zero wait states, unmapped addresses read zero with pslverr.
//        Map: 0x000 mode select, 0x004 function select, 0x008 clock control,
//        0x00C group summary (read only), 0x010 pin flags, 0x014 pin enables,
//        0x018 protection key. Flag and enable words take the group index in
//        data bits 19:16, for reads as well as writes.
// Behaviour
// - Mode bit 1 routes pin to peripheral
// - Two-bit function selector per pin
// - Selector only matters when mode bit set
// - Debug halt withholds clock unless run bit
// - Clock fields writable only while unlocked
// - Divide selected source by divide field
// - Two-bit source field picks the oscillator
// - Power-of-two ratios; external only 1/1
// - Filter samples at port clock rate
// - Unimplemented sources cannot be selected
// - Key reset when chosen P0 bits low
// - Group bit set when group interrupts
// - Group bit clears with its pin flags
// - Unsupported groups read as zero
// - Writing one clears a pin flag
// - Disabled pins never raise group bit
//
// The register offsets and the APB interface to the registers were left to the implementer.
`include "pfcc_consts.vh"
module pfcc_top #(
   parameter        NGRP     = 13,
   parameter [12:0] INT_GRPS = 13'h1FFF,
   parameter [3:0]  SRC_IMPL = 4'hF
) (
   // Clock and reset
   input  wire                 clk,
   input  wire                 srst,
   // APB
   input  wire                 psel,
   input  wire                 penable,
   input  wire                 pwrite,
   input  wire [11:0]          paddr,
   input  wire [31:0]          pwdata,
   output reg  [31:0]          prdata,
   output reg                  pready,
   output reg                  pslverr,
   // Clock sources as enables, debug halt
   input  wire [3:0]           src_tick,
   input  wire                 debug_halt,
   // Pins (p0_in group 0 only, pin_event every group; other groups replicate this block's selector registers)
   input  wire [7:0]           p0_in,
   input  wire [8*NGRP-1:0]    pin_event,
   // Pin routing
   output reg  [7:0]           periph_sel,
   output reg  [15:0]          func_sel,
   // Derived clock, key reset and group summary
   output reg                  port_clk_tick,
   output reg                  key_reset_req,
   output reg  [12:0]          group_int
);
   // ************************
   // Registers
   // ************************
   reg  [7:0]          modsel_r;
   reg  [15:0]         fncsel_r;
   reg  [8:0]          clkctl_r;
   reg  [8:0]          clkctl_nxt;
   reg                 unlocked_r;
   reg  [14:0]         div_cnt_r;
   reg  [14:0]         div_mask;
   reg                 src_pick;
   reg  [31:0]         rd_nxt;
   reg  [12:0]         grp_nxt;
   reg                 krst_nxt;
   reg                 hit;
   wire [8*NGRP-1:0]   flag_r;
   wire [8*NGRP-1:0]   ien_r;
   wire [NGRP-1:0]     grp_any;
   wire [15:0]         fsel_nxt;
   wire                wr_en;
   wire                setup;
   wire                wr_modsel;
   wire                wr_fncsel;
   wire                wr_clkctl;
   wire                wr_unlock;
   wire                wr_flag;
   wire                wr_ien;
   wire [3:0]          grp_idx;
   wire [1:0]          req_src;
   wire [1:0]          cur_src;
   wire [3:0]          cur_div;
   wire                src_gate;
   wire                src_en;
   wire                div_done;
   wire                keys_2;
   wire                keys_3;
   wire                keys_4;
   wire [31:0]         rd_modsel;
   wire [31:0]         rd_fncsel;
   wire [31:0]         rd_clkctl;
   wire [31:0]         rd_grp;
   wire [31:0]         rd_flag;
   wire [31:0]         rd_ien;
   wire [31:0]         rd_unlock;
   genvar              gi;
   genvar              pi;

   // ************************
   // Address decode
   // ************************
   // Writes land in the access cycle, the edge at which the master sees pready.
   assign wr_en     = psel & penable & pwrite;
   assign setup     = psel & ~penable;
   assign wr_modsel = wr_en & (paddr == `PFCC_OFS_MODSEL);
   assign wr_fncsel = wr_en & (paddr == `PFCC_OFS_FNCSEL);
   assign wr_clkctl = wr_en & (paddr == `PFCC_OFS_CLKCTL);
   assign wr_unlock = wr_en & (paddr == `PFCC_OFS_UNLOCK);
   assign wr_flag   = wr_en & (paddr == `PFCC_OFS_INTFLAG);
   assign wr_ien    = wr_en & (paddr == `PFCC_OFS_INTEN);
   // Group index for flag and enable words rides in the upper data half
   assign grp_idx   = pwdata[19:16];
   assign req_src   = pwdata[`PFCC_SRC_MSB:`PFCC_SRC_LSB];
   assign cur_src   = clkctl_r[`PFCC_SRC_MSB:`PFCC_SRC_LSB];
   assign cur_div   = clkctl_r[`PFCC_DIV_MSB:`PFCC_DIV_LSB];

   // ************************
   // Mode and function select
   // ************************
   always @(posedge clk) begin
      if (srst) begin
         modsel_r <= 8'h00;
         fncsel_r <= `PFCC_RST16;
      end else begin
         if (wr_modsel) begin
            modsel_r <= pwdata[7:0];
         end
         if (wr_fncsel) begin
            fncsel_r <= pwdata[15:0];
         end
      end
   end

   // ************************
   // Write protection key
   // ************************
   // Any other value relocks, so a stray write cannot leave the gate open.
   always @(posedge clk) begin
      if (srst) begin
         unlocked_r <= 1'b0;
      end else if (wr_unlock) begin
         unlocked_r <= (pwdata[15:0] == `PFCC_UNLOCK_KEY);
      end
   end

   // ************************
   // Clock control
   // ************************
   // An unimplemented source code keeps the old source; other fields still land.
   always @* begin
      clkctl_nxt = clkctl_r;
      if (wr_clkctl && unlocked_r) begin
         clkctl_nxt[`PFCC_DBG_RUN_BIT]             = pwdata[`PFCC_DBG_RUN_BIT];
         clkctl_nxt[`PFCC_DIV_MSB:`PFCC_DIV_LSB]   = pwdata[`PFCC_DIV_MSB:`PFCC_DIV_LSB];
         clkctl_nxt[`PFCC_KRST_MSB:`PFCC_KRST_LSB] = pwdata[`PFCC_KRST_MSB:`PFCC_KRST_LSB];
         if (SRC_IMPL[req_src]) begin
            clkctl_nxt[`PFCC_SRC_MSB:`PFCC_SRC_LSB] = req_src;
         end
      end
   end

   always @(posedge clk) begin
      if (srst) begin
         clkctl_r <= 9'h000;
      end else begin
         clkctl_r <= clkctl_nxt;
      end
   end

   // ************************
   // Port clock divider
   // ************************
   // Source pulses are gated before counting, so a debug halt freezes the phase.
   assign src_gate = ~debug_halt | clkctl_r[`PFCC_DBG_RUN_BIT];
   assign src_en   = src_pick & src_gate;

   always @* begin
      case (cur_src)
         `PFCC_SRC_INT:  src_pick = src_tick[0] & SRC_IMPL[0];
         `PFCC_SRC_LOSC: src_pick = src_tick[1] & SRC_IMPL[1];
         `PFCC_SRC_HOSC: src_pick = src_tick[2] & SRC_IMPL[2];
         default:        src_pick = src_tick[3] & SRC_IMPL[3];
      endcase
   end

   // Ratio 2^d: a tick when all counter bits below d are set.
   // The external input bypasses the divider whatever the divide code says.
   always @* begin
      if (cur_src == `PFCC_SRC_EXT) begin
         div_mask = 15'h0000;
      end else begin
         case (cur_div)
            4'h0:    div_mask = 15'h0000;
            4'h1:    div_mask = 15'h0001;
            4'h2:    div_mask = 15'h0003;
            4'h3:    div_mask = 15'h0007;
            4'h4:    div_mask = 15'h000F;
            4'h5:    div_mask = 15'h001F;
            4'h6:    div_mask = 15'h003F;
            4'h7:    div_mask = 15'h007F;
            4'h8:    div_mask = 15'h00FF;
            4'h9:    div_mask = 15'h01FF;
            4'hA:    div_mask = 15'h03FF;
            4'hB:    div_mask = 15'h07FF;
            4'hC:    div_mask = 15'h0FFF;
            4'hD:    div_mask = 15'h1FFF;
            4'hE:    div_mask = 15'h3FFF;
            default: div_mask = 15'h7FFF;
         endcase
      end
   end

   assign div_done = ((div_cnt_r & div_mask) == div_mask);

   always @(posedge clk) begin
      if (srst) begin
         div_cnt_r <= 15'h0000;
      end else if (src_en) begin
         div_cnt_r <= div_done ? 15'h0000 : div_cnt_r + 15'h0001;
      end
   end

   always @(posedge clk) begin
      if (srst) begin
         port_clk_tick <= 1'b0;
      end else begin
         port_clk_tick <= src_en & div_done;
      end
   end

   // ************************
   // Per-group flags and enables
   // ************************
   // One address serves every group; each group keeps its own flops.
   generate
      for (gi = 0; gi < NGRP; gi = gi + 1) begin : g_grp
         reg  [7:0]          flg_r;
         reg  [7:0]          en_r;
         wire                sel;
         wire [7:0]          clr;

         assign sel = (grp_idx == gi);
         assign clr = (wr_flag & sel) ? pwdata[7:0] : 8'h00;

         // Set beats clear: an event in the clearing cycle is not lost
         always @(posedge clk) begin
            if (srst) begin
               flg_r <= 8'h00;
            end else begin
               flg_r <= pin_event[gi*8 +: 8] | (flg_r & ~clr);
            end
         end

         always @(posedge clk) begin
            if (srst) begin
               en_r <= 8'h00;
            end else if (wr_ien & sel) begin
               en_r <= pwdata[7:0];
            end
         end

         assign flag_r[gi*8 +: 8] = flg_r;
         assign ien_r[gi*8 +: 8]  = en_r;
         // Disabled pins are masked; groups without interrupts are tied off
         assign grp_any[gi] = INT_GRPS[gi] & (|(flg_r & en_r));
      end
   endgenerate

   // ************************
   // Group summary, key reset
   // ************************
   assign keys_2 = ~|p0_in[1:0];
   assign keys_3 = ~|p0_in[2:0];
   assign keys_4 = ~|p0_in[3:0];

   always @* begin
      grp_nxt           = 13'h0000;
      grp_nxt[NGRP-1:0] = grp_any;
      case (clkctl_r[`PFCC_KRST_MSB:`PFCC_KRST_LSB])
         `PFCC_KRST_2: krst_nxt = keys_2;
         `PFCC_KRST_3: krst_nxt = keys_3;
         `PFCC_KRST_4: krst_nxt = keys_4;
         default:      krst_nxt = 1'b0;
      endcase
   end

   // Selector forced to zero on GPIO pins so a stale code never reaches a peripheral
   generate
      for (pi = 0; pi < 8; pi = pi + 1) begin : g_pin
         assign fsel_nxt[pi*2 +: 2] = modsel_r[pi] ? fncsel_r[pi*2 +: 2] : 2'h0;
      end
   endgenerate

   always @(posedge clk) begin
      if (srst) begin
         group_int     <= 13'h0000;
         key_reset_req <= 1'b0;
         periph_sel    <= 8'h00;
         func_sel      <= `PFCC_RST16;
      end else begin
         group_int     <= grp_nxt;
         key_reset_req <= krst_nxt;
         periph_sel    <= modsel_r;
         func_sel      <= fsel_nxt;
      end
   end

   // ************************
   // Bus reads
   // ************************
   assign rd_modsel = {24'h000000, modsel_r};
   assign rd_fncsel = {16'h0000, fncsel_r};
   assign rd_clkctl = {23'h000000, clkctl_r};
   assign rd_grp    = {19'h00000, group_int};
   assign rd_flag   = (grp_idx < NGRP) ? {24'h000000, flag_r[grp_idx*8 +: 8]} : 32'h0000_0000;
   assign rd_ien    = (grp_idx < NGRP) ? {24'h000000, ien_r[grp_idx*8 +: 8]} : 32'h0000_0000;
   assign rd_unlock = {31'h00000000, unlocked_r};

   always @* begin
      rd_nxt = 32'h0000_0000;
      hit    = 1'b1;
      case (paddr)
         `PFCC_OFS_MODSEL:  rd_nxt = rd_modsel;
         `PFCC_OFS_FNCSEL:  rd_nxt = rd_fncsel;
         `PFCC_OFS_CLKCTL:  rd_nxt = rd_clkctl;
         `PFCC_OFS_INTGRP:  rd_nxt = rd_grp;
         `PFCC_OFS_INTFLAG: rd_nxt = rd_flag;
         `PFCC_OFS_INTEN:   rd_nxt = rd_ien;
         `PFCC_OFS_UNLOCK:  rd_nxt = rd_unlock;
         default:           hit = 1'b0;
      endcase
   end

   // Answer in the cycle after setup: no wait states, yet every output is a flop.
   always @(posedge clk) begin
      if (srst) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= setup;
         pslverr <= setup & ~hit;
         prdata  <= (setup & ~pwrite) ? rd_nxt : 32'h0000_0000;
      end
   end
endmodule // pfcc_top

// File: dv/pfcc_monitor.sv
// Purpose: port checker for pfcc_top. Assumes: sync reset srst. Notes: bound below.
module pfcc_monitor #(parameter NGRP = 13, parameter [12:0] INT_GRPS = 13'h1FFF) (
   input wire logic clk, srst, psel, penable, pwrite, pready, pslverr, debug_halt,
   input wire logic port_clk_tick, key_reset_req,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata, prdata,
   input wire logic [3:0] src_tick,
   input wire logic [7:0] p0_in, periph_sel,
   input wire logic [8*NGRP-1:0] pin_event,
   input wire logic [15:0] func_sel,
   input wire logic [12:0] group_int);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] msk;
   always_comb for (int i = 0; i < 8; i++) msk[2*i+:2] = {2{periph_sel[i]}};
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   a_ready_cause: assert property (pready |-> psel && penable && $past(psel && !penable))
      else $error("pready without setup");
   a_ready_timely: assert property (psel && !penable |=> pready) else $error("pready late");
   a_err_unmapped: assert property (pslverr |-> pready && paddr > 12'h018) else $error("pslverr on mapped");
   a_ok_mapped: assert property (pready && paddr <= 12'h018 && paddr[1:0] == 2'h0 |-> !pslverr)
      else $error("mapped address refused");
   a_func_gated: assert property ((func_sel & ~msk) == 16'h0000) else $error("selector leaks");
   a_key_cause: assert property (key_reset_req |-> $past(p0_in[1:0]) == 2'h0)
      else $error("key reset without low pins");
   a_tick_cause: assert property (port_clk_tick |-> $past(|src_tick)) else $error("tick w/o source");
   a_group_absent: assert property ((group_int & ~INT_GRPS) == 13'h0000)
      else $error("absent group bit set");
   a_reset_quiet: assert property (disable iff (1'b0) srst |=> group_int == 13'h0000 && !key_reset_req
      && !port_clk_tick && !pready) else $error("output live after reset");
   c_key: cover property (key_reset_req);
   c_tick: cover property (port_clk_tick);
   c_group: cover property (|group_int);
endmodule // pfcc_monitor
bind pfcc_top pfcc_monitor #(.NGRP(NGRP), .INT_GRPS(INT_GRPS)) u_mon (.*);

// File: dv/pfcc_src_model.sv
// Purpose: clock source stand-in. Assumes: sources as enable pulses. Notes: source k every k+2 cycles.
module pfcc_src_model (input wire logic clk, input wire logic srst, output logic [3:0] src_tick);
   timeunit 1ns;
   timeprecision 1ns;
   int cnt [4];
   // Distinct periods so a wrong source choice shows in the tick count
   always @(posedge clk)
      for (int k = 0; k < 4; k++) begin
         cnt[k] <= (srst || cnt[k] == k + 1) ? 0 : cnt[k] + 1;
         src_tick[k] <= !srst && cnt[k] == k + 1;
      end
endmodule // pfcc_src_model

// File: dv/test_port_function_clock_control.sv
// Purpose: register-level test of pfcc_top. Assumes: APB answers in one access cycle. Notes: group 12 absent.
module test_port_function_clock_control;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, debug_halt = 0, pready, pslverr, rerr;
   logic port_clk_tick, key_reset_req;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rdat;
   logic [3:0] src_tick;
   logic [7:0] p0_in = 8'hF8, periph_sel;
   logic [103:0] pin_event = '0;
   logic [15:0] func_sel;
   logic [12:0] group_int;
   int num_errors = 0, compares = 0, cyc = 0, t, p;
   pfcc_top #(.INT_GRPS(13'h0FFF), .SRC_IMPL(4'hB)) DUT (.*);
   pfcc_src_model u_src (.clk(clk), .srst(srst), .src_tick(src_tick));
   initial forever #5 clk = ~clk;
   task summarize;
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         num_errors++;
         summarize;
      end
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge clk);
      penable <= 1;
      do @(posedge clk); while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   task evt(input int b);
      @(posedge clk) pin_event[b] <= 1;
      @(posedge clk) pin_event <= '0;
      repeat (3) @(posedge clk);
   endtask
   // Tick count over a fixed window, with the source pulses seen in it
   task meas(input logic [31:0] cfg, input logic h);
      debug_halt <= h;
      apb(1, 12'h008, cfg);
      t = 0;
      p = 0;
      repeat (200) @(posedge clk) begin
         t += port_clk_tick;
         p += src_tick[cfg[1:0]];
      end
      debug_halt <= 0;
   endtask
   function automatic logic near(int a, int b);
      return a <= b + 1 && b <= a + 1;
   endfunction
   initial begin
      repeat (3) @(posedge clk);
      srst <= 0;
      for (int a = 4; a <= 12; a += 4) begin
         apb(0, a[11:0], 0);
         chk(rdat, 0);
      end
      apb(1, 12'h000, 32'h05);
      apb(1, 12'h004, 32'hFFE4);
      repeat (2) @(posedge clk);
      chk(periph_sel, 32'h05);
      chk(func_sel, 32'h0020);
      apb(0, 12'h004, 0);
      chk(rdat, 32'hFFE4);
      apb(1, 12'h008, 32'h00F);
      apb(0, 12'h008, 0);
      chk(rdat, 0);
      apb(1, 12'h018, 32'h96);
      for (int c = 0; c < 4; c++) begin
         apb(1, 12'h008, c << 2);
         repeat (2) @(posedge clk);
         chk(key_reset_req, c == 1 || c == 2);
      end
      apb(1, 12'h008, 32'h001);
      apb(1, 12'h008, 32'h012);
      apb(0, 12'h008, 0);
      chk(rdat, 32'h011);
      meas(32'h021, 0);
      chk(near(t, p / 4), 1);
      meas(32'h023, 0);
      chk(near(t, p), 1);
      meas(32'h001, 1);
      chk(t, 0);
      meas(32'h101, 1);
      chk(near(t, p), 1);
      apb(1, 12'h014, 32'h1);
      evt(0);
      evt(1);
      chk(group_int, 1);
      apb(0, 12'h00C, 0);
      chk(rdat, 1);
      apb(1, 12'h010, 0);
      chk(group_int, 1);
      apb(1, 12'h010, 32'h1);
      repeat (2) @(posedge clk);
      chk(group_int, 0);
      apb(1, 12'h014, 32'h000C0001);
      evt(96);
      chk(group_int, 0);
      apb(0, 12'h020, 0);
      chk({rerr, rdat[30:0]}, 32'h80000000);
      summarize;
   end
endmodule // test_port_function_clock_control
